// ===== src/scp_master.sv
// bus master end: user commands on mclk, bus engine on the link clock
module scp_master
  import scp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  scp_link_if.mst         link,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic       cmd_sel,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            done,
  output logic            rsp_nack,
  output logic [7:0]      rsp_rdata
);

  // ------------------------------------------------------------------
  // user side (mclk)
  // ------------------------------------------------------------------
  logic       hold_rd_r, hold_sel_r, req_tgl_r;
  logic [7:0] hold_addr_r, hold_wdata_r;
  logic       dn_s1_r, dn_s2_r, dn_d_r;
  logic       dn_tgl_r, res_nack_r;
  logic [7:0] res_rdata_r;
  logic       accept, done_evt;

  assign accept   = cmd_valid & cmd_ready;
  assign done_evt = dn_s2_r ^ dn_d_r;

  // command held stable while the link side works on it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_rd_r    <= 1'b0;
      hold_sel_r   <= 1'b0;
      hold_addr_r  <= 8'h00;
      hold_wdata_r <= 8'h00;
      req_tgl_r    <= 1'b0;
      cmd_ready    <= 1'b1;
    end
    else if (accept)
    begin
      hold_rd_r    <= cmd_read;
      hold_sel_r   <= cmd_sel;
      hold_addr_r  <= cmd_addr;
      hold_wdata_r <= cmd_wdata;
      req_tgl_r    <= ~req_tgl_r;
      cmd_ready    <= 1'b0;
    end
    else if (done_evt)
      cmd_ready <= 1'b1;
  end

  // completion toggle back from the link side; results are stable by then
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dn_s1_r   <= 1'b0;
      dn_s2_r   <= 1'b0;
      dn_d_r    <= 1'b0;
      done      <= 1'b0;
      rsp_nack  <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      dn_s1_r <= dn_tgl_r;
      dn_s2_r <= dn_s1_r;
      dn_d_r  <= dn_s2_r;
      done    <= done_evt;
      if (done_evt)
      begin
        rsp_nack  <= res_nack_r;
        rsp_rdata <= res_rdata_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // link side (link_clk)
  // ------------------------------------------------------------------
  scp_mst_e   st_r, item_nxt;
  logic [2:0] step_r, ph_r;
  logic [3:0] bi_r;
  logic       rq_s1_r, rq_s2_r, rq_d_r, go;
  logic       sd_s1_r, sd_s2_r;
  logic       scl_low_r, sda_low_r;
  logic [7:0] txb;

  assign go = rq_s2_r ^ rq_d_r;

  // item sequence: write = S A R D P, read = S A R Sr A' D P
  always_comb
  begin
    unique case (step_r + 3'h1)
      3'h1, 3'h2:  item_nxt = SCP_M_TX;
      3'h3:        item_nxt = hold_rd_r ? SCP_M_START : SCP_M_TX;
      3'h4:        item_nxt = hold_rd_r ? SCP_M_TX : SCP_M_STOP;
      3'h5:        item_nxt = SCP_M_RX;
      default:     item_nxt = SCP_M_STOP;
    endcase
    unique case (step_r)
      3'h1:    txb = scp_addr_byte(hold_sel_r, 1'b0);
      3'h2:    txb = hold_addr_r;
      3'h3:    txb = hold_wdata_r;
      default: txb = scp_addr_byte(hold_sel_r, 1'b1);
    endcase
  end

  // request crossing and data line input synchroniser
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_d_r  <= 1'b0;
      sd_s1_r <= 1'b1;
      sd_s2_r <= 1'b1;
    end
    else
    begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      rq_d_r  <= rq_s2_r;
      sd_s1_r <= link.sda;
      sd_s2_r <= sd_s1_r;
    end
  end

  // item sequencer: eight link cycles per bus bit
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r     <= SCP_M_IDLE;
      step_r   <= 3'h0;
      ph_r     <= 3'h0;
      bi_r     <= 4'h0;
      dn_tgl_r <= 1'b0;
    end
    else if (st_r == SCP_M_IDLE)
    begin
      ph_r   <= 3'h0;
      bi_r   <= 4'h0;
      step_r <= 3'h0;
      if (go)
        st_r <= SCP_M_START;
    end
    else
    begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == SCP_PH_LAST)
      begin
        if ((st_r == SCP_M_TX || st_r == SCP_M_RX) && bi_r != SCP_BIT_ACK)
          bi_r <= bi_r + 4'h1;
        else if (st_r == SCP_M_STOP)
        begin
          st_r     <= SCP_M_IDLE;
          dn_tgl_r <= ~dn_tgl_r;
        end
        else
        begin
          bi_r   <= 4'h0;
          step_r <= step_r + 3'h1;
          // refused byte: go straight to stop
          st_r   <= (st_r == SCP_M_TX && sd_s2_r) ? SCP_M_STOP : item_nxt;
        end
      end
    end
  end

  // pin drive by phase; start, repeated start and stop shapes
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        SCP_M_START:
        begin
          if (ph_r == SCP_PH_DATA)   sda_low_r <= 1'b0;
          if (ph_r == SCP_PH_CLK_UP) scl_low_r <= 1'b0;
          if (ph_r == SCP_PH_MID)    sda_low_r <= 1'b1;
          if (ph_r == SCP_PH_CLK_DN) scl_low_r <= 1'b1;
        end
        SCP_M_TX, SCP_M_RX:
        begin
          // msb first; release on ack slot and for read bits
          if (ph_r == SCP_PH_DATA)
            sda_low_r <= (st_r == SCP_M_TX) && (bi_r != SCP_BIT_ACK)
                         && !txb[3'(SCP_BIT_LAST - bi_r)];
          if (ph_r == SCP_PH_MID)  scl_low_r <= 1'b0;
          if (ph_r == SCP_PH_LAST) scl_low_r <= 1'b1;
        end
        SCP_M_STOP:
        begin
          if (ph_r == SCP_PH_DATA)   sda_low_r <= 1'b1;
          if (ph_r == SCP_PH_CLK_UP) scl_low_r <= 1'b0;
          if (ph_r == SCP_PH_MID)    sda_low_r <= 1'b0;
        end
        SCP_M_IDLE:
        begin
          scl_low_r <= 1'b0;
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  // sampling at the end of the high half; results held for mclk
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_nack_r  <= 1'b0;
      res_rdata_r <= 8'h00;
    end
    else if (st_r == SCP_M_IDLE && go)
      res_nack_r <= 1'b0;
    else if (ph_r == SCP_PH_LAST)
    begin
      if (st_r == SCP_M_TX && bi_r == SCP_BIT_ACK && sd_s2_r)
        res_nack_r <= 1'b1;
      if (st_r == SCP_M_RX && bi_r != SCP_BIT_ACK)
        res_rdata_r <= {res_rdata_r[6:0], sd_s2_r};
    end
  end

  assign link.scl_m_o    = 1'b0;
  assign link.sda_m_o    = 1'b0;
  assign link.scl_m_oe_n = ~scl_low_r;
  assign link.sda_m_oe_n = ~sda_low_r;

endmodule

// ===== src/scp_pkg.sv
// shared constants, types and helpers for the serial control port
package scp_pkg;

  // ------------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------------
  localparam logic [5:0] SCP_ADDR_HI = 6'h26;  // upper six address bits
  localparam logic [7:0] SCP_REG_TOP = 8'h1E;  // highest register address
  localparam logic [7:0] SCP_PTR_RST = 8'h00;  // register pointer at reset

  // ------------------------------------------------------------------
  // bit framing
  // ------------------------------------------------------------------
  localparam logic [3:0] SCP_BIT_LAST = 4'h7;  // eighth data bit
  localparam logic [3:0] SCP_BIT_ACK  = 4'h8;  // acknowledge slot
  localparam logic [3:0] SCP_BIT_PRE  = 4'hF;  // after start, before fall

  // ------------------------------------------------------------------
  // link timing, in link clock cycles per phase slot
  // ------------------------------------------------------------------
  localparam int         SCP_SLOTS     = 8;    // link cycles per bus bit
  localparam logic [2:0] SCP_PH_DATA   = 3'h0; // data line set
  localparam logic [2:0] SCP_PH_CLK_UP = 3'h2; // clock released (frames)
  localparam logic [2:0] SCP_PH_MID    = 3'h4; // mid step
  localparam logic [2:0] SCP_PH_CLK_DN = 3'h6; // clock pulled (start)
  localparam logic [2:0] SCP_PH_LAST   = 3'(SCP_SLOTS - 1);

  // ------------------------------------------------------------------
  // state types
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    SCP_D_IDLE  = 5'h01,
    SCP_D_ADDR  = 5'h02,
    SCP_D_REG   = 5'h04,
    SCP_D_WDATA = 5'h08,
    SCP_D_RDATA = 5'h10
  } scp_dev_e;

  typedef enum logic [4:0] {
    SCP_M_IDLE  = 5'h01,
    SCP_M_START = 5'h02,
    SCP_M_TX    = 5'h04,
    SCP_M_RX    = 5'h08,
    SCP_M_STOP  = 5'h10
  } scp_mst_e;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // saturating register pointer advance
  function automatic logic [7:0] scp_next_ptr(input logic [7:0] ptr);
    scp_next_ptr = (ptr >= SCP_REG_TOP) ? SCP_REG_TOP : ptr + 8'h01;
  endfunction

  // slave address byte on the wire
  function automatic logic [7:0] scp_addr_byte(input logic sel,
                                               input logic rd);
    scp_addr_byte = {SCP_ADDR_HI, sel, rd};
  endfunction

endpackage

// ===== src/scp_link_if.sv
// two-wire link between the control port master and the device
interface scp_link_if;
  logic scl_m_o;     // master clock drive value
  logic scl_m_oe_n;  // master clock enable, low drives
  logic sda_m_o;     // master data drive value
  logic sda_m_oe_n;  // master data enable, low drives
  logic sda_s_o;     // device data drive value
  logic sda_s_oe_n;  // device data enable, low drives
  logic scl;         // resolved clock wire
  logic sda;         // resolved data wire

  // pull-ups win unless a driver pulls low
  assign scl = scl_m_oe_n ? 1'b1 : scl_m_o;
  assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);

  modport mst (output scl_m_o, scl_m_oe_n, sda_m_o, sda_m_oe_n,
               input  scl, sda);
  modport dev (output sda_s_o, sda_s_oe_n,
               input  scl, sda);
endinterface

// ===== src/scp_slave.sv
// device end: two-wire control port slave running on the link clock
// --------------------------------------------------------------------
// --------------------------------------------------------------------
module scp_slave
  import scp_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  scp_link_if.dev         link,
  input  wire logic       address_select_pin,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  input  wire logic [7:0] reg_rdata
);

  // ------------------------------------------------------------------
  // input synchronisers and line events
  // ------------------------------------------------------------------
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic asel_s1_r, asel_s2_r;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // the first stage feeds only the second; edges use stage two onward
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s1_r  <= 1'b1;
      scl_s2_r  <= 1'b1;
      scl_d_r   <= 1'b1;
      sda_s1_r  <= 1'b1;
      sda_s2_r  <= 1'b1;
      sda_d_r   <= 1'b1;
      asel_s1_r <= 1'b0;
      asel_s2_r <= 1'b0;
    end
    else
    begin
      scl_s1_r  <= link.scl;
      scl_s2_r  <= scl_s1_r;
      scl_d_r   <= scl_s2_r;
      sda_s1_r  <= link.sda;
      sda_s2_r  <= sda_s1_r;
      sda_d_r   <= sda_s2_r;
      asel_s1_r <= address_select_pin;
      asel_s2_r <= asel_s1_r;
    end
  end

  assign scl_rise  = scl_s2_r & ~scl_d_r;
  assign scl_fall  = ~scl_s2_r & scl_d_r;
  // data edges with the clock steady high are frame marks
  assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // ------------------------------------------------------------------
  // byte framing decisions
  // ------------------------------------------------------------------
  scp_dev_e   state_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shreg_r;
  logic [7:0] ptr_r;
  logic       rw_r, acked_r, mack_r, oe_n_r;
  logic       byte_done, ack_done, addr_hit, reg_ok, ack_give, go_rd;

  assign byte_done = scl_fall && bitcnt_r == SCP_BIT_LAST;
  assign ack_done  = scl_fall && bitcnt_r == SCP_BIT_ACK;
  assign addr_hit  = shreg_r[7:1] == {SCP_ADDR_HI, asel_s2_r};
  assign reg_ok    = shreg_r <= SCP_REG_TOP;

  // acknowledge choice at the end of the eighth bit
  always_comb
  begin
    unique case (state_r)
      SCP_D_ADDR:  ack_give = addr_hit;
      SCP_D_REG:   ack_give = reg_ok;
      SCP_D_WDATA: ack_give = 1'b1;
      default:     ack_give = 1'b0;
    endcase
  end

  // byte to be sent after this ack slot: first or next read byte
  assign go_rd = (state_r == SCP_D_ADDR && acked_r && rw_r)
              || (state_r == SCP_D_RDATA && mack_r);

  // ------------------------------------------------------------------
  // protocol state
  // ------------------------------------------------------------------
  // start or repeated start always reopens address phase
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= SCP_D_IDLE;
    else if (bus_start)
      state_r <= SCP_D_ADDR;
    else if (bus_stop)
      state_r <= SCP_D_IDLE;
    else if (ack_done)
    begin
      unique case (state_r)
        SCP_D_ADDR:
          if (!acked_r)
            state_r <= SCP_D_IDLE;
          else
            state_r <= rw_r ? SCP_D_RDATA : SCP_D_REG;
        SCP_D_REG:
          state_r <= acked_r ? SCP_D_WDATA : SCP_D_IDLE;
        SCP_D_RDATA:
          state_r <= mack_r ? SCP_D_RDATA : SCP_D_IDLE;
        SCP_D_WDATA, SCP_D_IDLE:
          state_r <= state_r;
      endcase
    end
  end

  // bit position: 0..7 data, 8 acknowledge slot
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      bitcnt_r <= 4'h0;
    else if (bus_start)
      // the start's own clock fall wraps this to bit 0
      bitcnt_r <= SCP_BIT_PRE;
    else if (bus_stop)
      bitcnt_r <= 4'h0;
    else if (scl_fall)
      bitcnt_r <= (bitcnt_r == SCP_BIT_ACK) ? 4'h0 : bitcnt_r + 4'h1;
  end

  // shifter: sample on rising clock, present read bits on falling
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      shreg_r <= 8'h00;
    else if (ack_done && go_rd)
      shreg_r <= reg_rdata;
    else if (state_r == SCP_D_RDATA)
    begin
      if (scl_fall && bitcnt_r < SCP_BIT_LAST)
        shreg_r <= {shreg_r[6:0], 1'b0};
    end
    else if (state_r != SCP_D_IDLE && scl_rise && bitcnt_r < SCP_BIT_ACK)
      shreg_r <= {shreg_r[6:0], sda_s2_r};
  end

  // per-byte flags: direction, own ack, master ack
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rw_r    <= 1'b0;
      acked_r <= 1'b0;
      mack_r  <= 1'b0;
    end
    else
    begin
      if (byte_done)
        acked_r <= ack_give;
      if (byte_done && state_r == SCP_D_ADDR)
        rw_r <= shreg_r[0];
      if (scl_rise && bitcnt_r == SCP_BIT_ACK && state_r == SCP_D_RDATA)
        mack_r <= ~sda_s2_r;
    end
  end

  // ------------------------------------------------------------------
  // data line drive (open drain, low enable pulls the line)
  // ------------------------------------------------------------------
  // set after a detected clock fall, forced released on start or stop, so never pulled low while clock high
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_n_r <= 1'b1;
    else if (bus_start || bus_stop)
      oe_n_r <= 1'b1;
    else if (byte_done)
      // refused bytes simply stay released
      oe_n_r <= (state_r == SCP_D_RDATA) ? 1'b1 : ~ack_give;
    else if (ack_done)
      oe_n_r <= go_rd ? reg_rdata[7] : 1'b1;
    else if (scl_fall && state_r == SCP_D_RDATA && bitcnt_r < SCP_BIT_LAST)
      oe_n_r <= shreg_r[6];
  end

  assign link.sda_s_o    = 1'b0;
  assign link.sda_s_oe_n = oe_n_r;

  // ------------------------------------------------------------------
  // register pointer and write strobe
  // ------------------------------------------------------------------
  // base from the register byte, then saturating advance
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= SCP_PTR_RST;
    else if (ack_done && state_r == SCP_D_REG && acked_r)
      ptr_r <= shreg_r;
    else if (ack_done && state_r == SCP_D_WDATA)
      ptr_r <= scp_next_ptr(ptr_r);
    else if (byte_done && state_r == SCP_D_RDATA)
      ptr_r <= scp_next_ptr(ptr_r);
  end

  assign reg_addr = ptr_r;

  // one-cycle write pulse when a data byte completes
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_we    <= 1'b0;
      reg_wdata <= 8'h00;
    end
    else
    begin
      reg_we <= byte_done && state_r == SCP_D_WDATA;
      if (byte_done && state_r == SCP_D_WDATA)
        reg_wdata <= shreg_r;
    end
  end

endmodule

// ===== test/scp_props.sv
// link checker: device and master behaviour seen on the two wires
module scp_props
  import scp_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // bus decoder
  // ------------------------------------------------------------------
  logic       scl_r;
  logic       sda_r;
  logic       rd_r;
  logic       adr_ok_r;
  logic       reg_ok_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  wire        start = scl && scl_r && sda_r && !sda;
  wire        stop  = scl && scl_r && !sda_r && sda;
  wire        ack   = scl && !scl_r && bit_r == SCP_BIT_ACK;

  // previous line levels, so edges need no sampled-value calls
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_r <= 1'h1;
      sda_r <= 1'h1;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end

  // bit and byte position since the last start
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_r  <= 4'h0;
      byte_r <= 2'h0;
      sh_r   <= 8'h00;
    end
    else if (start)
    begin
      bit_r  <= 4'h0;
      byte_r <= 2'h0;
    end
    else if (scl && !scl_r)
    begin
      bit_r <= ack ? 4'h0 : bit_r + 4'h1;
      sh_r  <= ack ? sh_r : {sh_r[6:0], sda};
      if (ack && byte_r != 2'h3)
        byte_r <= byte_r + 2'h1;
    end
  end

  // direction and acknowledge history; byte count saturates at 3
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_r     <= 1'h0;
      adr_ok_r <= 1'h0;
      reg_ok_r <= 1'h0;
    end
    else if (start)
    begin
      rd_r     <= 1'h0;
      adr_ok_r <= 1'h0;
      reg_ok_r <= 1'h0;
    end
    else if (ack && byte_r == 2'h0)
    begin
      rd_r     <= sh_r[0];
      adr_ok_r <= !sda;
    end
    else if (ack && byte_r == 2'h1)
      reg_ok_r <= adr_ok_r && !rd_r && !sda;
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!rst_n);

  chk_dev_stable_hi: assert property (
    scl && scl_r |-> $stable(sda_s_oe_n))
    else $error("device data moved while clock high");
  chk_addr_own: assert property (
    ack && byte_r == 2'h0 && !sda_s_oe_n |-> sh_r[7:2] == SCP_ADDR_HI)
    else $error("foreign address acknowledged");
  chk_addr_other: assert property (
    ack && byte_r == 2'h0 && sh_r[7:2] != SCP_ADDR_HI |-> sda_s_oe_n [*8])
    else $error("foreign address not ignored");
  chk_reg_range: assert property (
    ack && byte_r == 2'h1 && adr_ok_r && !rd_r
    |-> sda_s_oe_n == (sh_r > SCP_REG_TOP))
    else $error("register address acknowledge wrong");
  chk_reg_nack_free: assert property (
    ack && byte_r == 2'h1 && !rd_r && sh_r > SCP_REG_TOP |=> sda_s_oe_n [*8])
    else $error("data line held after refused write");
  chk_wdata_ack: assert property (
    ack && byte_r[1] && !rd_r && reg_ok_r |-> !sda_s_oe_n)
    else $error("write data byte not acknowledged");
  chk_wr_dev_quiet: assert property (
    scl && scl_r && !rd_r && bit_r != 4'h0 |-> sda_s_oe_n)
    else $error("device drove data during a write bit");
  chk_rd_end_free: assert property (
    ack && rd_r && byte_r != 2'h0 && sda |=> sda_s_oe_n [*8])
    else $error("device kept driving after end of data");
  chk_rd_end_stop: assert property (
    ack && rd_r && byte_r != 2'h0 && sda |-> ##[1:16] stop)
    else $error("no stop after last read byte");
  chk_stop_idle: assert property (
    stop |=> sda_s_oe_n [*8])
    else $error("device drove the bus after stop");
  chk_mst_ack_free: assert property (
    ack && !rd_r |-> sda_m_oe_n)
    else $error("master held data in device acknowledge slot");

  // main scenarios reached
  cov_wdata: cover property (ack && byte_r[1] && !sda_s_oe_n);
  cov_rd_end: cover property (ack && rd_r && byte_r != 2'h0 && sda);
  cov_rstart: cover property (start && adr_ok_r);
  cov_reg_nack: cover property (ack && byte_r == 2'h1 && !rd_r && sda);
endmodule

// ===== test/tb_top.sv
// bench: command master and device joined over the two-wire link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       rd;
    logic       pin;
    logic       sel;
    logic [7:0] addr;
    logic [7:0] wd;
    logic       nack;
    logic [7:0] rdat;
    logic [7:0] ptr;
  } scp_row_s;

  // rd pin sel addr wdata nack rdata pointer-after
  localparam scp_row_s ROWS [10] = '{
    {1'h0, 1'h0, 1'h0, 8'h05, 8'hA5, 1'h0, 8'h00, 8'h06},
    {1'h1, 1'h0, 1'h0, 8'h05, 8'h00, 1'h0, 8'hA5, 8'h06},
    {1'h0, 1'h1, 1'h0, 8'h00, 8'h77, 1'h1, 8'h00, 8'h00},
    {1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0, 8'h00, 8'h01},
    {1'h0, 1'h1, 1'h1, 8'h1E, 8'h3C, 1'h0, 8'h00, 8'h1E},
    {1'h1, 1'h1, 1'h1, 8'h1E, 8'h00, 1'h0, 8'h3C, 8'h1E},
    {1'h0, 1'h1, 1'h1, 8'h1F, 8'h99, 1'h1, 8'h00, 8'h00},
    {1'h1, 1'h0, 1'h1, 8'h05, 8'h00, 1'h1, 8'h00, 8'h00},
    {1'h0, 1'h0, 1'h0, 8'h00, 8'h81, 1'h0, 8'h00, 8'h01},
    {1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0, 8'h81, 8'h01}};

  logic       mclk, link_clk, rst_n, cmd_valid, cmd_read, cmd_sel;
  logic       address_select_pin, cmd_ready, done, rsp_nack, reg_we;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, reg_addr, reg_wdata;
  logic [7:0] reg_rdata, wbyte;
  logic [7:0] regs [32];
  int         n_mismatch, n_checks, wcnt;

  // clocks; a link rising edge never falls on an mclk rising edge
  always #5 mclk = ~mclk;
  always #32 link_clk = ~link_clk;

  scp_link_if link_if ();
  scp_master u_scp_master (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .link(link_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .done(done), .rsp_nack(rsp_nack),
    .rsp_rdata(rsp_rdata));
  scp_slave u_scp_slave (.link_clk(link_clk), .rst_n(rst_n), .link(link_if),
    .address_select_pin(address_select_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata));
  scp_props u_scp_props (.link_clk(link_clk), .rst_n(rst_n),
    .scl(link_if.scl), .sda(link_if.sda), .sda_m_oe_n(link_if.sda_m_oe_n),
    .sda_s_oe_n(link_if.sda_s_oe_n));

  // register file behind the device, read side combinational
  assign reg_rdata = regs[reg_addr[4:0]];
  always @(posedge link_clk)
    if (reg_we)
      regs[reg_addr[4:0]] <= reg_wdata;

  // last address byte after a start, taken from the wire itself
  always @(negedge link_if.sda)
    if (link_if.scl)
      wcnt = 0;
  always @(posedge link_if.scl)
    if (wcnt < 8)
    begin
      wbyte = {wbyte[6:0], link_if.sda};
      wcnt++;
    end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one command; the master is idle here, so it is taken at once
  task automatic run_row(input scp_row_s r);
    int k;
    @(posedge mclk);
    address_select_pin <= r.pin;
    cmd_valid <= 1'h1;
    cmd_read  <= r.rd;
    cmd_sel   <= r.sel;
    cmd_addr  <= r.addr;
    cmd_wdata <= r.wd;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    while (done !== 1'h1 && k < 4000);
    check({7'h00, done}, 8'h01);
    check({7'h00, rsp_nack}, {7'h00, r.nack});
    check(wbyte, {6'h26, r.sel, r.rd & ~r.nack});
    if (!r.nack)
    begin
      check(reg_addr, r.ptr);
      check(r.rd ? rsp_rdata : regs[r.addr[4:0]], r.rd ? r.rdat : r.wd);
    end
    check({link_if.scl, link_if.sda, 6'h00}, 8'hC0);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    mclk = 1'h0;
    link_clk = 1'h0;
    rst_n = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_sel = 1'h0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    address_select_pin = 1'h0;
    wbyte = 8'h00;
    wcnt = 8;
    n_mismatch = 0;
    n_checks = 0;
    foreach (regs[i])
      regs[i] = 8'h00;
    // held over two link edges as well, the slower domain
    repeat (2) @(posedge link_clk);
    @(posedge mclk);
    rst_n <= 1'h1;
    repeat (4) @(posedge link_clk);
    foreach (ROWS[i])
      run_row(ROWS[i]);
    // reset in mid-transfer: lines must free and the pointer clear
    @(posedge mclk);
    cmd_valid <= 1'h1;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    repeat (300) @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge link_clk);
    #1;
    check({link_if.scl, link_if.sda, cmd_ready, done}, 8'h0E);
    check(reg_addr, 8'h00);
    @(posedge mclk);
    rst_n <= 1'h1;
    repeat (4) @(posedge link_clk);
    run_row(ROWS[9]);
    print_verdict;
  end

  // watchdog, about three times the expected run
  initial
  begin
    #600_000;
    n_mismatch++;
    print_verdict;
  end
endmodule
